// File: shared/tis_consts.svh
`ifndef TIS_CONSTS_SVH
`define TIS_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TIS_CLK_PERIOD_NS 4
`define TIS_RESET_HOLD_NS 1000
`define TIS_RESET_HOLD_CYC ((`TIS_RESET_HOLD_NS + `TIS_CLK_PERIOD_NS - 1) / `TIS_CLK_PERIOD_NS)
`define TIS_RELEASE_WAIT_NS 1000
`define TIS_RELEASE_WAIT_CYC \
    ((`TIS_RELEASE_WAIT_NS + `TIS_CLK_PERIOD_NS - 1) / `TIS_CLK_PERIOD_NS)

// ----------------------------------------
// Parameter values written to the sensor
// ----------------------------------------
`define TIS_VAL_ON 16'h0001
`define TIS_VAL_OFF 16'h0000
`define TIS_VAL_INIT01 16'h000A
`define TIS_VAL_INIT2 16'h0001
`define TIS_VAL_UPD_MASTER 16'h0002
`define TIS_VAL_UPD_SLAVE 16'h0000

// ----------------------------------------
// Timing table
// ----------------------------------------
`define TIS_TBL_DEPTH 8
`define TIS_TBL_IDX_W 3

`endif

// File: shared/tis_pkg.sv
package tis_pkg;

    // Logical parameter selectors; the transport passes them to the sensor unchanged
    typedef enum logic [7:0] {
        TIS_P_TIMING_GEN_ENABLE = 8'h01,
        TIS_P_STANDBY = 8'h02,
        TIS_P_INIT_0 = 8'h03,
        TIS_P_INIT_1 = 8'h04,
        TIS_P_INIT_2 = 8'h05,
        TIS_P_UPDATE_SELECT = 8'h06,
        TIS_P_AUTO_POWERDOWN_ENABLE = 8'h07,
        TIS_P_AMBIENT_GATE_ENABLE = 8'h08,
        TIS_P_ILLUM_DRIVER_ENABLE = 8'h09,
        TIS_P_ILLUM_DRIVER_CURRENT = 8'h0A
    } tis_param_t;

    typedef enum logic [4:0] {
        TIS_S_IDLE = 5'h00,
        TIS_S_RST_HOLD = 5'h01,
        TIS_S_RST_WAIT = 5'h03,
        TIS_S_TG_ON = 5'h02,
        TIS_S_STBY_OFF = 5'h06,
        TIS_S_TG_OFF = 5'h07,
        TIS_S_INIT0 = 5'h05,
        TIS_S_INIT1 = 5'h04,
        TIS_S_INIT2 = 5'h0C,
        TIS_S_UPD_SEL = 5'h0D,
        TIS_S_AUTO_PDN = 5'h0F,
        TIS_S_AMB_GATE = 5'h0E,
        TIS_S_TIMING = 5'h0A,
        TIS_S_DRV_EN = 5'h0B,
        TIS_S_DRV_CUR = 5'h09,
        TIS_S_TG_FINAL = 5'h08,
        TIS_S_DONE = 5'h18
    } tis_state_t;

    typedef enum logic [1:0] {
        TIS_W_IDLE = 2'b00,
        TIS_W_REQ = 2'b01,
        TIS_W_REL = 2'b11
    } tis_wstate_t;

    typedef struct packed {
        logic [7:0] id;
        logic [15:0] val;
    } tis_tbl_entry_t;

    typedef struct packed {
        tis_state_t state;
        logic [15:0] cnt;
        logic [2:0] tidx;
        logic issued;
        logic sensor_reset_n;
        logic busy;
        logic done;
        tis_tbl_entry_t [7:0] tbl;
    } tis_seq_regs_t;

    typedef struct packed {
        tis_wstate_t state;
        logic done_meta;
        logic done_sync;
        logic req;
        logic [7:0] param;
        logic [15:0] data;
        logic ack;
    } tis_port_regs_t;

endpackage

// File: shared/tis_wr_if.sv
`timescale 1ns/1ps

interface tis_wr_if;
    logic start;
    logic [7:0] param;
    logic [15:0] data;
    logic ack;
    logic idle;

    modport seq (
        output start,
        output param,
        output data,
        input ack,
        input idle
    );

    modport port (
        input start,
        input param,
        input data,
        output ack,
        output idle
    );
endinterface

// File: core/tis_write_port.sv
`timescale 1ns/1ps
`include "tis_consts.svh"

module tis_write_port (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Sequencer side
    tis_wr_if.port wr,
    // Sensor parameter transport
    output logic wr_req_o,
    output logic [7:0] wr_param_o,
    output logic [15:0] wr_data_o,
    input wire logic wr_done_i
);
    tis_pkg::tis_port_regs_t r_reg;
    tis_pkg::tis_port_regs_t r_next;

    // ----------------------------------------
    // Four-phase handshake toward the sensor
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        r_next.done_meta = wr_done_i;
        r_next.done_sync = r_reg.done_meta;
        r_next.ack = 1'b0;
        case (r_reg.state)
            tis_pkg::TIS_W_IDLE: begin
                // Wait for previous done to fall before a new request
                if (wr.start && !r_reg.done_sync) begin
                    r_next.req = 1'b1;
                    r_next.param = wr.param;
                    r_next.data = wr.data;
                    r_next.state = tis_pkg::TIS_W_REQ;
                end
            end
            tis_pkg::TIS_W_REQ: begin
                if (r_reg.done_sync) begin
                    r_next.req = 1'b0;
                    r_next.state = tis_pkg::TIS_W_REL;
                end
            end
            tis_pkg::TIS_W_REL: begin
                // Only complete once the sensor drops done
                if (!r_reg.done_sync) begin
                    r_next.ack = 1'b1;
                    r_next.state = tis_pkg::TIS_W_IDLE;
                end
            end
            default: begin
                r_next.state = tis_pkg::TIS_W_IDLE;
                r_next.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign wr.ack = r_reg.ack;
    assign wr.idle = (r_reg.state == tis_pkg::TIS_W_IDLE) && !r_reg.done_sync;
    assign wr_req_o = r_reg.req;
    assign wr_param_o = r_reg.param;
    assign wr_data_o = r_reg.data;
endmodule

// File: core/tis_init_ctrl.sv
`timescale 1ns/1ps
`include "tis_consts.svh"

// Summary of operation
// - Host holds sensor reset pin low before any configuration write.
// - First write sets timing generator enable; final write sets it again.
// - Next, standby is cleared to zero.
// - Then timing generator enable is written zero.
// - Both first and second init parameters get 0Ah.
// - Third init parameter gets 01h.
// - Update select is 02h as sync master, 00h as slave.
// - Optionally write auto power-down enable as one.
// - Optionally write ambient gate enable as one under strong light.
// - Timing parameters go after init writes, before the final enable.
// - With illumination driver used, enable it and write its current.
module tis_init_ctrl (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // User control
    input wire logic start_i,
    input wire logic sync_master_i,
    input wire logic auto_powerdown_i,
    input wire logic ambient_gate_i,
    input wire logic illum_use_i,
    input wire logic [15:0] illum_current_i,
    // Timing table load
    input wire logic tbl_wr_i,
    input wire logic [2:0] tbl_idx_i,
    input wire logic [7:0] tbl_id_i,
    input wire logic [15:0] tbl_val_i,
    input wire logic [3:0] tbl_count_i,
    // User status
    output logic busy_o,
    output logic done_o,
    output logic [4:0] step_o,
    // Sensor pins
    output logic sensor_reset_n_o,
    output logic wr_req_o,
    output logic [7:0] wr_param_o,
    output logic [15:0] wr_data_o,
    input wire logic wr_done_i
);
    localparam logic [15:0] HOLD_CYC = 16'(`TIS_RESET_HOLD_CYC);
    localparam logic [15:0] WAIT_CYC = 16'(`TIS_RELEASE_WAIT_CYC);

    tis_pkg::tis_seq_regs_t r_reg;
    tis_pkg::tis_seq_regs_t r_next;
    tis_wr_if wr ();

    logic [7:0] w_param;
    logic [15:0] w_data;
    logic w_is_write;
    logic tbl_empty;
    logic tbl_last;
    tis_pkg::tis_tbl_entry_t cur_entry;

    assign tbl_empty = (tbl_count_i == 4'h0);
    // Counts above the table depth stop at the last entry instead of looping
    assign tbl_last = (r_reg.tidx == 3'h7) || ({1'b0, r_reg.tidx} + 4'h1 >= tbl_count_i);
    assign cur_entry = r_reg.tbl[r_reg.tidx];

    // ----------------------------------------
    // Parameter and value of each write step
    // ----------------------------------------
    always_comb begin
        w_is_write = 1'b1;
        w_param = 8'h00;
        w_data = `TIS_VAL_OFF;
        case (r_reg.state)
            tis_pkg::TIS_S_TG_ON: begin
                w_param = tis_pkg::TIS_P_TIMING_GEN_ENABLE;
                w_data = `TIS_VAL_ON;
            end
            tis_pkg::TIS_S_STBY_OFF: begin
                w_param = tis_pkg::TIS_P_STANDBY;
                w_data = `TIS_VAL_OFF;
            end
            tis_pkg::TIS_S_TG_OFF: begin
                w_param = tis_pkg::TIS_P_TIMING_GEN_ENABLE;
                w_data = `TIS_VAL_OFF;
            end
            tis_pkg::TIS_S_INIT0: begin
                w_param = tis_pkg::TIS_P_INIT_0;
                w_data = `TIS_VAL_INIT01;
            end
            tis_pkg::TIS_S_INIT1: begin
                w_param = tis_pkg::TIS_P_INIT_1;
                w_data = `TIS_VAL_INIT01;
            end
            tis_pkg::TIS_S_INIT2: begin
                w_param = tis_pkg::TIS_P_INIT_2;
                w_data = `TIS_VAL_INIT2;
            end
            tis_pkg::TIS_S_UPD_SEL: begin
                w_param = tis_pkg::TIS_P_UPDATE_SELECT;
                w_data = sync_master_i ? `TIS_VAL_UPD_MASTER : `TIS_VAL_UPD_SLAVE;
            end
            tis_pkg::TIS_S_AUTO_PDN: begin
                // Sensor then parks idle subsystems itself
                w_param = tis_pkg::TIS_P_AUTO_POWERDOWN_ENABLE;
                w_data = `TIS_VAL_ON;
            end
            tis_pkg::TIS_S_AMB_GATE: begin
                w_param = tis_pkg::TIS_P_AMBIENT_GATE_ENABLE;
                w_data = `TIS_VAL_ON;
            end
            tis_pkg::TIS_S_TIMING: begin
                w_param = cur_entry.id;
                w_data = cur_entry.val;
            end
            tis_pkg::TIS_S_DRV_EN: begin
                w_param = tis_pkg::TIS_P_ILLUM_DRIVER_ENABLE;
                w_data = `TIS_VAL_ON;
            end
            tis_pkg::TIS_S_DRV_CUR: begin
                w_param = tis_pkg::TIS_P_ILLUM_DRIVER_CURRENT;
                w_data = illum_current_i;
            end
            tis_pkg::TIS_S_TG_FINAL: begin
                w_param = tis_pkg::TIS_P_TIMING_GEN_ENABLE;
                w_data = `TIS_VAL_ON;
            end
            default: begin
                w_is_write = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        r_next = r_reg;
        // Table is frozen while a sequence runs
        if (tbl_wr_i && !r_reg.busy) begin
            r_next.tbl[tbl_idx_i].id = tbl_id_i;
            r_next.tbl[tbl_idx_i].val = tbl_val_i;
        end
        r_next.done = 1'b0;
        if (w_is_write && !r_reg.issued && wr.idle) begin
            r_next.issued = 1'b1;
        end
        case (r_reg.state)
            tis_pkg::TIS_S_IDLE: begin
                if (start_i) begin
                    r_next.busy = 1'b1;
                    r_next.sensor_reset_n = 1'b0;
                    r_next.cnt = HOLD_CYC;
                    r_next.state = tis_pkg::TIS_S_RST_HOLD;
                end
            end
            tis_pkg::TIS_S_RST_HOLD: begin
                if (r_reg.cnt <= 16'h0001) begin
                    r_next.sensor_reset_n = 1'b1;
                    r_next.cnt = WAIT_CYC;
                    r_next.state = tis_pkg::TIS_S_RST_WAIT;
                end else begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end
            end
            tis_pkg::TIS_S_RST_WAIT: begin
                // Sensor settles into standby before the first write
                if (r_reg.cnt <= 16'h0001) begin
                    r_next.state = tis_pkg::TIS_S_TG_ON;
                end else begin
                    r_next.cnt = r_reg.cnt - 16'h0001;
                end
            end
            tis_pkg::TIS_S_DONE: begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
                r_next.state = tis_pkg::TIS_S_IDLE;
            end
            default: begin
                if (r_reg.issued && wr.ack) begin
                    r_next.issued = 1'b0;
                    case (r_reg.state)
                        tis_pkg::TIS_S_TG_ON: r_next.state = tis_pkg::TIS_S_STBY_OFF;
                        tis_pkg::TIS_S_STBY_OFF: r_next.state = tis_pkg::TIS_S_TG_OFF;
                        tis_pkg::TIS_S_TG_OFF: r_next.state = tis_pkg::TIS_S_INIT0;
                        tis_pkg::TIS_S_INIT0: r_next.state = tis_pkg::TIS_S_INIT1;
                        tis_pkg::TIS_S_INIT1: r_next.state = tis_pkg::TIS_S_INIT2;
                        tis_pkg::TIS_S_INIT2: r_next.state = tis_pkg::TIS_S_UPD_SEL;
                        tis_pkg::TIS_S_UPD_SEL: begin
                            r_next.state = auto_powerdown_i ? tis_pkg::TIS_S_AUTO_PDN :
                                ambient_gate_i ? tis_pkg::TIS_S_AMB_GATE :
                                !tbl_empty ? tis_pkg::TIS_S_TIMING :
                                illum_use_i ? tis_pkg::TIS_S_DRV_EN : tis_pkg::TIS_S_TG_FINAL;
                        end
                        tis_pkg::TIS_S_AUTO_PDN: begin
                            r_next.state = ambient_gate_i ? tis_pkg::TIS_S_AMB_GATE :
                                !tbl_empty ? tis_pkg::TIS_S_TIMING :
                                illum_use_i ? tis_pkg::TIS_S_DRV_EN : tis_pkg::TIS_S_TG_FINAL;
                        end
                        tis_pkg::TIS_S_AMB_GATE: begin
                            r_next.state = !tbl_empty ? tis_pkg::TIS_S_TIMING :
                                illum_use_i ? tis_pkg::TIS_S_DRV_EN : tis_pkg::TIS_S_TG_FINAL;
                        end
                        tis_pkg::TIS_S_TIMING: begin
                            if (tbl_last) begin
                                r_next.tidx = 3'h0;
                                r_next.state = illum_use_i ? tis_pkg::TIS_S_DRV_EN :
                                    tis_pkg::TIS_S_TG_FINAL;
                            end else begin
                                r_next.tidx = r_reg.tidx + 3'h1;
                            end
                        end
                        tis_pkg::TIS_S_DRV_EN: r_next.state = tis_pkg::TIS_S_DRV_CUR;
                        tis_pkg::TIS_S_DRV_CUR: r_next.state = tis_pkg::TIS_S_TG_FINAL;
                        default: r_next.state = tis_pkg::TIS_S_DONE;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    // Start pulses for exactly the cycle the port accepts
    assign wr.start = w_is_write && !r_reg.issued && wr.idle;
    assign wr.param = w_param;
    assign wr.data = w_data;

    tis_write_port u_port (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .wr(wr),
        .wr_req_o(wr_req_o),
        .wr_param_o(wr_param_o),
        .wr_data_o(wr_data_o),
        .wr_done_i(wr_done_i)
    );

    assign busy_o = r_reg.busy;
    assign done_o = r_reg.done;
    assign step_o = r_reg.state;
    // Low through host reset: sensor stays held until a sequence runs
    assign sensor_reset_n_o = r_reg.sensor_reset_n;
endmodule

// File: verification/tis_init_ctrl_assertions.sv
`timescale 1ns/1ps

module tis_init_ctrl_chk (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // User side
    input wire logic start_i,
    input wire logic sync_master_i,
    input wire logic [15:0] illum_current_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [4:0] step_o,
    // Sensor side
    input wire logic sensor_reset_n_o,
    input wire logic wr_req_o,
    input wire logic [7:0] wr_param_o,
    input wire logic [15:0] wr_data_o,
    input wire logic wr_done_i
);
    wire logic [23:0] word_w = {wr_param_o, wr_data_o};

    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    // ----------------------------------------
    // Reset pin and start
    // ----------------------------------------
    a_hold_no_write: assert property (!sensor_reset_n_o |-> !wr_req_o)
        else $error("write issued while sensor held");
    a_hold_long: assert property ($rose(sensor_reset_n_o) |-> !$past(sensor_reset_n_o, 200))
        else $error("sensor reset released too early");
    a_start_holds: assert property (start_i && !busy_o |=> busy_o && !sensor_reset_n_o)
        else $error("start did not hold sensor in reset");

    // ----------------------------------------
    // Written values per step
    // ----------------------------------------
    a_tg_enable: assert property (wr_req_o && (step_o == tis_pkg::TIS_S_TG_ON
        || step_o == tis_pkg::TIS_S_TG_FINAL)
        |-> word_w == {tis_pkg::TIS_P_TIMING_GEN_ENABLE, 16'h0001})
        else $error("bad timing generator enable write");
    a_standby_exit: assert property (wr_req_o && step_o == tis_pkg::TIS_S_STBY_OFF
        |-> word_w == {tis_pkg::TIS_P_STANDBY, 16'h0000})
        else $error("bad standby write");
    a_tg_disable: assert property (wr_req_o && step_o == tis_pkg::TIS_S_TG_OFF
        |-> word_w == {tis_pkg::TIS_P_TIMING_GEN_ENABLE, 16'h0000})
        else $error("bad timing generator disable write");
    a_init_pair: assert property (wr_req_o && (step_o == tis_pkg::TIS_S_INIT0
        || step_o == tis_pkg::TIS_S_INIT1) |-> wr_data_o == 16'h000a)
        else $error("bad first or second init value");
    a_init_third: assert property (wr_req_o && step_o == tis_pkg::TIS_S_INIT2
        |-> word_w == {tis_pkg::TIS_P_INIT_2, 16'h0001})
        else $error("bad third init write");
    a_update_select: assert property (wr_req_o && step_o == tis_pkg::TIS_S_UPD_SEL
        |-> wr_data_o == (sync_master_i ? 16'h0002 : 16'h0000))
        else $error("bad update select value");
    a_option_ones: assert property (wr_req_o && (step_o == tis_pkg::TIS_S_AUTO_PDN
        || step_o == tis_pkg::TIS_S_AMB_GATE || step_o == tis_pkg::TIS_S_DRV_EN)
        |-> wr_data_o == 16'h0001)
        else $error("optional enable not written as one");
    a_drv_current: assert property (wr_req_o && step_o == tis_pkg::TIS_S_DRV_CUR
        |-> word_w == {tis_pkg::TIS_P_ILLUM_DRIVER_CURRENT, illum_current_i})
        else $error("bad illumination current write");

    // ----------------------------------------
    // Handshake discipline
    // ----------------------------------------
    a_req_held: assert property ($rose(wr_req_o) |-> wr_req_o [*3])
        else $error("write request dropped early");
    a_req_stable: assert property (wr_req_o && $past(wr_req_o)
        |-> $stable(wr_param_o) && $stable(wr_data_o))
        else $error("write word changed during request");
    a_req_gap: assert property ($rose(wr_req_o)
        |-> !$past(wr_done_i, 1) && !$past(wr_done_i, 2))
        else $error("new request before completion cleared");
    a_done_pulse: assert property (done_o |-> !wr_req_o ##1 !done_o)
        else $error("done not a single quiet cycle");
endmodule

bind tis_init_ctrl tis_init_ctrl_chk u_chk (.*);

// File: verification/tis_sensor_model.sv
`timescale 1ns/1ps

module tis_sensor_model (
    // Clock and reset pin
    input wire logic sys_clk_i,
    input wire logic sensor_reset_n_i,
    // Parameter transport
    input wire logic wr_req_i,
    input wire logic [7:0] wr_param_i,
    input wire logic [15:0] wr_data_i,
    input wire logic [3:0] lat_i,
    output logic wr_done_o
);
    logic [3:0] wait_reg;
    logic standby_reg;
    logic tg_reg;
    logic pdn_reg;
    logic subsys_on;
    logic [23:0] log_q [$];

    // Outside standby, idle blocks sleep only when auto power-down is set
    assign subsys_on = !standby_reg && (tg_reg || !pdn_reg);

    always @(posedge sys_clk_i) begin
        if (!sensor_reset_n_i) begin
            standby_reg <= 1'b1;
            tg_reg <= 1'b0;
            pdn_reg <= 1'b0;
            wait_reg <= 4'h0;
            wr_done_o <= 1'b0;
        end else if (wr_req_i != wr_done_o) begin
            if (wait_reg < lat_i) begin
                wait_reg <= wait_reg + 4'h1;
            end else begin
                wait_reg <= 4'h0;
                wr_done_o <= wr_req_i;
                if (wr_req_i) begin
                    log_q.push_back({wr_param_i, wr_data_i});
                    case (wr_param_i)
                        tis_pkg::TIS_P_STANDBY: standby_reg <= wr_data_i[0];
                        tis_pkg::TIS_P_TIMING_GEN_ENABLE: tg_reg <= wr_data_i[0];
                        tis_pkg::TIS_P_AUTO_POWERDOWN_ENABLE: pdn_reg <= wr_data_i[0];
                        default: ;
                    endcase
                end
            end
        end
    end
endmodule

// File: verification/tis_init_ctrl_test.sv
`timescale 1ns/1ps

module tis_init_ctrl_test;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic start_i = 1'b0;
    logic sync_master_i = 1'b0;
    logic auto_powerdown_i = 1'b0;
    logic ambient_gate_i = 1'b0;
    logic illum_use_i = 1'b0;
    logic [15:0] illum_current_i = 16'h0000;
    logic tbl_wr_i = 1'b0;
    logic [2:0] tbl_idx_i = 3'h0;
    logic [7:0] tbl_id_i = 8'h00;
    logic [15:0] tbl_val_i = 16'h0000;
    logic [3:0] tbl_count_i = 4'h0;
    logic [3:0] lat_i = 4'h0;
    logic busy_o;
    logic done_o;
    logic [4:0] step_o;
    logic sensor_reset_n_o;
    logic wr_req_o;
    logic [7:0] wr_param_o;
    logic [15:0] wr_data_o;
    logic wr_done_i;
    logic [31:0] seed = 32'h0001_4bb4;
    logic [23:0] tbl_m [8];
    logic [23:0] exp_q [$];
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;

    tis_init_ctrl u_dut (.*);

    tis_sensor_model u_sensor (
        .sys_clk_i(sys_clk_i),
        .sensor_reset_n_i(sensor_reset_n_o),
        .wr_req_i(wr_req_o),
        .wr_param_i(wr_param_o),
        .wr_data_i(wr_data_o),
        .lat_i(lat_i),
        .wr_done_o(wr_done_i)
    );

    always #2 sys_clk_i = ~sys_clk_i;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard well above six full sequences
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic reset_dut(input int cycles);
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        repeat (cycles) @(posedge sys_clk_i);
        reset_i <= 1'b0;
    endtask

    task automatic pulse_start();
        @(posedge sys_clk_i);
        start_i <= 1'b1;
        @(posedge sys_clk_i);
        start_i <= 1'b0;
    endtask

    task automatic load_tbl();
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            // Ids kept clear of the named selectors so model state checks hold
            tbl_m[i] = {1'b1, seed[22:0]};
            @(posedge sys_clk_i);
            tbl_wr_i <= 1'b1;
            tbl_idx_i <= 3'(i);
            {tbl_id_i, tbl_val_i} <= tbl_m[i];
        end
        @(posedge sys_clk_i);
        tbl_wr_i <= 1'b0;
    endtask

    // opt: slow sensor, master, auto power-down, ambient gate, illumination driver
    task automatic run_seq(input logic [4:0] opt, input logic [3:0] cnt, input logic refuse);
        int n;
        n = 0;
        seed = lfsr(seed);
        @(posedge sys_clk_i);
        {lat_i, sync_master_i, auto_powerdown_i, ambient_gate_i, illum_use_i}
            <= {opt[4] ? 4'hb : 4'h0, opt[3:0]};
        illum_current_i <= seed[15:0];
        tbl_count_i <= cnt;
        pulse_start();
        exp_q = {};
        exp_q.push_back({tis_pkg::TIS_P_TIMING_GEN_ENABLE, 16'h0001});
        exp_q.push_back({tis_pkg::TIS_P_STANDBY, 16'h0000});
        exp_q.push_back({tis_pkg::TIS_P_TIMING_GEN_ENABLE, 16'h0000});
        exp_q.push_back({tis_pkg::TIS_P_INIT_0, 16'h000a});
        exp_q.push_back({tis_pkg::TIS_P_INIT_1, 16'h000a});
        exp_q.push_back({tis_pkg::TIS_P_INIT_2, 16'h0001});
        exp_q.push_back({tis_pkg::TIS_P_UPDATE_SELECT, opt[3] ? 16'h0002 : 16'h0000});
        if (opt[2]) exp_q.push_back({tis_pkg::TIS_P_AUTO_POWERDOWN_ENABLE, 16'h0001});
        if (opt[1]) exp_q.push_back({tis_pkg::TIS_P_AMBIENT_GATE_ENABLE, 16'h0001});
        for (int i = 0; i < int'(cnt); i++) exp_q.push_back(tbl_m[i]);
        if (opt[0]) begin
            exp_q.push_back({tis_pkg::TIS_P_ILLUM_DRIVER_ENABLE, 16'h0001});
            exp_q.push_back({tis_pkg::TIS_P_ILLUM_DRIVER_CURRENT, seed[15:0]});
        end
        exp_q.push_back({tis_pkg::TIS_P_TIMING_GEN_ENABLE, 16'h0001});
        repeat (100) @(negedge sys_clk_i);
        check("sensor_reset_n", 32'h0, 32'(sensor_reset_n_o));
        check("wr_req", 32'h0, 32'(wr_req_o));
        check("busy", 32'h1, 32'(busy_o));
        check("step", 32'(tis_pkg::TIS_S_RST_HOLD), 32'(step_o));
        // Start and table load mid-run must both be ignored; last entry is still unread
        if (refuse) begin
            repeat (500) @(posedge sys_clk_i);
            start_i <= 1'b1;
            tbl_wr_i <= 1'b1;
            tbl_idx_i <= 3'h7;
            {tbl_id_i, tbl_val_i} <= ~tbl_m[7];
            @(posedge sys_clk_i);
            start_i <= 1'b0;
            tbl_wr_i <= 1'b0;
        end
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (done_o !== 1'b1 && n < 9000);
        check("done", 32'h1, 32'(done_o));
        check("write count", exp_q.size(), u_sensor.log_q.size());
        foreach (exp_q[i]) begin
            check("write word", 32'(exp_q[i]), 32'(u_sensor.log_q[i]));
        end
        repeat (2) @(negedge sys_clk_i);
        check("done end", 32'h0, 32'(done_o));
        check("busy end", 32'h0, 32'(busy_o));
        check("step end", 32'(tis_pkg::TIS_S_IDLE), 32'(step_o));
        check("standby", 32'h0, 32'(u_sensor.standby_reg));
        check("tg final", 32'h1, 32'(u_sensor.tg_reg));
        check("auto pdn", 32'(opt[2]), 32'(u_sensor.pdn_reg));
        u_sensor.log_q = {};
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset_dut(4);
        load_tbl();
        run_seq(5'b0_1111, 4'h8, 1'b1);
        run_seq(5'b1_0000, 4'h0, 1'b0);
        // Abort mid-write; a clean run must still follow
        pulse_start();
        repeat (700) @(posedge sys_clk_i);
        reset_dut(2);
        @(negedge sys_clk_i);
        check("busy abort", 32'h0, 32'(busy_o));
        check("sensor_reset_n abort", 32'h0, 32'(sensor_reset_n_o));
        u_sensor.log_q = {};
        // Reset wipes the timing table, so it is loaded afresh
        load_tbl();
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            run_seq(seed[4:0], 4'(seed[7:5]) + 4'(seed[8]), 1'b0);
        end
        tally_and_finish();
    end
endmodule
